// ---- design/move_swap_instruction_exec.sv ----
// executor for move, swap, literal load, store and idle instructions
`timescale 1ns/1ns
module move_swap_instruction_exec (
    input wire logic clk,
    input wire logic reset_n,
    input wire move_swap_pkg::insn_t insn_in,
    output logic busy,
    output logic [7:0] working_r,
    output logic zero_flag_r,
    output logic done_r,
    output move_swap_pkg::file_wr_t file_wr_r,
    input wire logic ext_wr_en,
    input wire logic [4:0] ext_wr_addr,
    input wire logic [7:0] ext_wr_data
);
    // one word is offered at a time; move and swap need a second cycle
    // because the operand comes out of a registered file read
    // two-step sequencer: fetch takes a word, exec retires a file op
    typedef enum logic {
        ST_FETCH,
        ST_EXEC
    } state_t;

    // sequencer state
    state_t state_r, state_nxt;               // sequencer state
    logic [11:0] word_r, word_nxt;            // held instruction word
    // next values of the architectural state and the outputs
    logic [7:0] working_nxt;                  // next working register
    logic zero_nxt;                           // next zero flag
    logic done_nxt;                           // next completion pulse
    move_swap_pkg::file_wr_t wr_nxt;          // next file write
    // decode results
    move_swap_pkg::op_t op_now, op_held;      // decode of incoming and held words
    // file port wiring
    logic [7:0] file_rd;                      // registered file read data
    logic [7:0] result;                       // computed result for file ops
    logic [4:0] rd_addr;                      // read address to memory
    logic mem_wr_en;                          // merged write enable
    logic [4:0] mem_wr_addr;                  // merged write address
    logic [7:0] mem_wr_data;                  // merged write data

    // classify an instruction word
    // the all-zero word is tested first so it never falls into another group;
    // used for both the offered and the held word
    function automatic move_swap_pkg::op_t decode(input logic [11:0] w);
        if (w == move_swap_pkg::IDLE_WORD) begin
            // idle word
            decode = move_swap_pkg::OP_IDLE;
        end else if (w[11:6] == move_swap_pkg::MOVE_FILE_TOP) begin
            // move file: bit 5 picks the destination, bits 4:0 the register
            decode = move_swap_pkg::OP_MOVE;
        end else if (w[11:6] == move_swap_pkg::SWAP_TOP) begin
            // nibble exchange: same destination and address fields as move
            decode = move_swap_pkg::OP_SWAP;
        end else if (w[11:5] == move_swap_pkg::STORE_TOP) begin
            // store working: bits 4:0 name the target register
            decode = move_swap_pkg::OP_STORE;
        end else if (w[11:8] == move_swap_pkg::LITERAL_TOP) begin
            // load literal: bits 7:0 carry the value
            decode = move_swap_pkg::OP_LITERAL;
        end else begin
            // any other word retires with no effect
            decode = move_swap_pkg::OP_OTHER;
        end
    endfunction

    // decode of the offered word steers the fetch step
    assign op_now = decode(insn_in.word);
    // decode of the held word steers the exec step
    assign op_held = decode(word_r);
    // address the file as soon as the word arrives so data is ready next cycle
    assign rd_addr = insn_in.word[4:0];
    // handshake: block cannot take a word while a file op executes;
    // a word offered then is dropped, not queued
    assign busy = (state_r == ST_EXEC);

    // outside writes share the port when the block itself is not writing;
    // an outside write that meets an internal write in one cycle is lost
    assign mem_wr_en = file_wr_r.en | ext_wr_en;
    assign mem_wr_addr = file_wr_r.en ? file_wr_r.addr : ext_wr_addr;
    assign mem_wr_data = file_wr_r.en ? file_wr_r.data : ext_wr_data;

    // operand storage; read data arrive one edge after the address
    // the write port takes the merged internal or outside write
    file_regs #(
        .DEPTH(move_swap_pkg::FILE_DEPTH),
        .AW(move_swap_pkg::ADDR_W),
        .DW(move_swap_pkg::DATA_W)
    ) u_file (
        .clk(clk),
        .rd_addr(rd_addr),
        .wr_en(mem_wr_en),
        .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_data),
        .rd_data(file_rd)
    );

    // forward a pending write to the same address, since memory read is stale then
    logic [7:0] file_val;      // operand seen by file ops
    logic fwd_r, fwd_nxt;      // forward flag
    logic [7:0] fwd_data_r;    // forwarded value
    logic [7:0] fwd_data_nxt;  // next forwarded value

    // compare the write entering the file with the address being read;
    // the file returns the old word on such a collision, so keep a copy
    always_comb begin
        fwd_nxt = mem_wr_en && (mem_wr_addr == rd_addr);
        fwd_data_nxt = mem_wr_data;
    end

    // prefer the kept copy over the stale read data
    assign file_val = fwd_r ? fwd_data_r : file_rd;

    // result of the held file op: exchange nibbles for swap, pass for move
    always_comb begin
        if (op_held == move_swap_pkg::OP_SWAP) begin
            result = {file_val[3:0], file_val[7:4]};
        end else begin
            result = file_val;
        end
    end

    // next state of the executor
    // defaults: hold every register, no completion pulse, no file write
    // a single case on the state keeps fetch and exec from overlapping
    always_comb begin
        state_nxt = state_r;
        word_nxt = word_r;
        working_nxt = working_r;
        zero_nxt = zero_flag_r;
        done_nxt = 1'b0;
        wr_nxt = '0;
        unique case (state_r)
            ST_FETCH: begin
                // take a word whenever one is offered
                if (insn_in.valid) begin
                    unique case (op_now)
                        move_swap_pkg::OP_MOVE, move_swap_pkg::OP_SWAP: begin
                            // operand read in flight; finish next cycle
                            word_nxt = insn_in.word;
                            state_nxt = ST_EXEC;
                        end
                        move_swap_pkg::OP_LITERAL: begin
                            // literal lands in working; flags untouched
                            working_nxt = insn_in.word[7:0];
                            done_nxt = 1'b1;
                        end
                        move_swap_pkg::OP_STORE: begin
                            // working value goes to the addressed register; flags untouched
                            wr_nxt.en = 1'b1;
                            wr_nxt.addr = insn_in.word[4:0];
                            wr_nxt.data = working_r;
                            done_nxt = 1'b1;
                        end
                        default: begin
                            // idle and foreign words retire with no effect
                            done_nxt = 1'b1;
                        end
                    endcase
                end
            end
            ST_EXEC: begin
                // retire the held move or swap
                if (word_r[move_swap_pkg::DEST_BIT]) begin
                    // write back to the same file register
                    wr_nxt.en = 1'b1;
                    wr_nxt.addr = word_r[4:0];
                    wr_nxt.data = result;
                end else begin
                    // destination is the working register
                    working_nxt = result;
                end
                // only move touches the zero flag; swap leaves it alone
                if (op_held == move_swap_pkg::OP_MOVE) begin
                    zero_nxt = (result == 8'h00);
                end
                done_nxt = 1'b1;
                state_nxt = ST_FETCH;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= ST_FETCH;
            word_r <= move_swap_pkg::IDLE_WORD;
        end else begin
            state_r <= state_nxt;
            word_r <= word_nxt;
        end
    end

    // working register and zero flag
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            working_r <= move_swap_pkg::WORK_RESET;
            zero_flag_r <= move_swap_pkg::ZERO_RESET;
        end else begin
            working_r <= working_nxt;
            zero_flag_r <= zero_nxt;
        end
    end

    // completion pulse and the write toward the file port
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done_r <= 1'b0;
            file_wr_r <= '0;
        end else begin
            done_r <= done_nxt;
            file_wr_r <= wr_nxt;
        end
    end

    // forwarding registers; cleared in reset so no stale copy
    // can stand in for the operand of the first file op
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fwd_r <= 1'b0;
            fwd_data_r <= 8'h00;
        end else begin
            fwd_r <= fwd_nxt;
            fwd_data_r <= fwd_data_nxt;
        end
    end
endmodule

// ---- design/move_swap_pkg.sv ----
// package with encodings, widths, reset values and carriers for the move/swap executor
// Notes on behaviour
// - move file passes addressed value unchanged
// - dest bit 0 to working, 1 to file
// - move file updates zero flag
// - swap exchanges upper and lower nibbles
// - swap dest bit selects working or file
package move_swap_pkg;
    localparam int DATA_W = 8;                       // data path width
    localparam int INSN_W = 12;                      // instruction word width
    localparam int ADDR_W = 5;                       // file address width
    localparam int FILE_DEPTH = 32;                  // number of file registers
    localparam int DEST_BIT = 5;                     // destination select position
    localparam logic [5:0] MOVE_FILE_TOP = 6'h08;    // bits 11:6 of move file
    localparam logic [5:0] SWAP_TOP = 6'h0e;         // bits 11:6 of nibble exchange
    localparam logic [6:0] STORE_TOP = 7'h01;        // bits 11:5 of store working
    localparam logic [3:0] LITERAL_TOP = 4'hc;       // bits 11:8 of load literal
    localparam logic [11:0] IDLE_WORD = 12'h000;     // idle word
    localparam logic [7:0] WORK_RESET = 8'h00;       // working register after reset
    localparam logic ZERO_RESET = 1'b0;              // zero flag after reset

    // decoded operation
    typedef enum logic [2:0] {
        OP_IDLE,
        OP_MOVE,
        OP_SWAP,
        OP_STORE,
        OP_LITERAL,
        OP_OTHER
    } op_t;

    // one instruction presented to the block
    typedef struct packed {
        logic valid;                 // word present this cycle
        logic [INSN_W-1:0] word;     // instruction word
    } insn_t;

    // file write request toward the memory
    typedef struct packed {
        logic en;                    // write this cycle
        logic [ADDR_W-1:0] addr;     // target address
        logic [DATA_W-1:0] data;     // value
    } file_wr_t;
endpackage

// ---- design/file_regs.sv ----
// small register file with registered read data
`timescale 1ns/1ns
module file_regs #(
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic [AW-1:0] rd_addr,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];  // storage

    // write port and registered read port; read returns old data on a collision
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ---- verification/move_swap_props.sv ----
// assertion checker for the move/swap executor ports
`timescale 1ns/1ns
module move_swap_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire move_swap_pkg::insn_t insn_in,
    input wire logic busy,
    input wire logic [7:0] working_r,
    input wire logic zero_flag_r,
    input wire logic done_r,
    input wire move_swap_pkg::file_wr_t file_wr_r,
    input wire logic ext_wr_en,
    input wire logic [4:0] ext_wr_addr,
    input wire logic [7:0] ext_wr_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // offer accepted this cycle
    wire logic take = insn_in.valid && !busy;
    // accepted move and swap words
    sequence s_move; take && insn_in.word[11:6] == move_swap_pkg::MOVE_FILE_TOP; endsequence
    sequence s_swap; take && insn_in.word[11:6] == move_swap_pkg::SWAP_TOP; endsequence
    // busy second cycle, then retirement
    sequence s_retire; busy ##1 done_r; endsequence
    AST_MOVE_RETIRE: assert property (s_move |=> s_retire)
        else $error("move did not retire in two cycles");
    AST_MOVE_DEST: assert property (s_move |-> ##2 file_wr_r.en == $past(insn_in.word[5], 2)
        && (!file_wr_r.en || file_wr_r.addr == $past(insn_in.word[4:0], 2)))
        else $error("move destination wrong");
    AST_MOVE_ZERO: assert property (s_move |-> ##2
        zero_flag_r == ((file_wr_r.en ? file_wr_r.data : working_r) == 8'h00))
        else $error("zero flag does not follow moved value");
    AST_SWAP_RETIRE: assert property (s_swap |=> s_retire)
        else $error("swap did not retire in two cycles");
    AST_SWAP_DEST: assert property (s_swap |-> ##2 file_wr_r.en == $past(insn_in.word[5], 2)
        && zero_flag_r == $past(zero_flag_r, 2))
        else $error("swap destination or flag wrong");
    AST_LITERAL: assert property (take && insn_in.word[11:8] == move_swap_pkg::LITERAL_TOP
        |=> done_r && working_r == $past(insn_in.word[7:0]) && $stable(zero_flag_r))
        else $error("literal load wrong");
    AST_STORE: assert property (take && insn_in.word[11:5] == move_swap_pkg::STORE_TOP
        |=> done_r && file_wr_r.en && file_wr_r.data == $past(working_r)
        && file_wr_r.addr == $past(insn_in.word[4:0]))
        else $error("store write wrong");
    AST_IDLE: assert property (take && insn_in.word == move_swap_pkg::IDLE_WORD
        |=> done_r && !file_wr_r.en && $stable(working_r) && $stable(zero_flag_r))
        else $error("idle word changed state");
endmodule

bind move_swap_instruction_exec move_swap_props u_props (.clk(clk), .reset_n(reset_n),
    .insn_in(insn_in), .busy(busy), .working_r(working_r), .zero_flag_r(zero_flag_r),
    .done_r(done_r), .file_wr_r(file_wr_r), .ext_wr_en(ext_wr_en),
    .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data));

// ---- verification/tb.sv ----
// self-checking bench for the move/swap executor
`timescale 1ns/1ns
module tb;
    logic clk, reset_n, ext_wr_en, busy, zero_flag_r, done_r;
    logic [4:0] ext_wr_addr;
    logic [7:0] ext_wr_data, working_r;
    move_swap_pkg::insn_t insn_in;
    move_swap_pkg::file_wr_t file_wr_r, fw; // fw: write seen at retirement
    int num_errors = 0;
    int checked = 0;
    int lat = 0; // edges waited past the first in the last run
    move_swap_instruction_exec dut (.clk(clk), .reset_n(reset_n), .insn_in(insn_in),
        .busy(busy), .working_r(working_r), .zero_flag_r(zero_flag_r), .done_r(done_r),
        .file_wr_r(file_wr_r), .ext_wr_en(ext_wr_en), .ext_wr_addr(ext_wr_addr),
        .ext_wr_data(ext_wr_data));
    // compare one value and count it
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // print counts and verdict, then stop
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // preload one file register through the outside port
    task automatic poke(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        ext_wr_en <= 1'b1;
        ext_wr_addr <= a;
        ext_wr_data <= d;
        @(posedge clk);
        ext_wr_en <= 1'b0;
    endtask
    // offer one word, wait bounded for retirement, capture the write
    task automatic run(input logic [11:0] w);
        int n = 0;
        @(posedge clk);
        insn_in <= {1'b1, w};
        @(posedge clk);
        insn_in <= '0;
        #1;
        while (done_r !== 1'b1) begin
            if (n++ == 4) begin
                num_errors++;
                report_and_stop();
            end
            @(posedge clk);
            #1;
        end
        lat = n;
        fw = file_wr_r;
    endtask
    // literal, store, idle and foreign words
    task automatic sc_flat();
        run(12'hc00);
        chk(14'(zero_flag_r), 14'h0000);
        chk(14'(lat), 14'h0000);
        run(12'hca5);
        chk(14'(working_r), 14'h00a5);
        run(12'h027);
        chk(fw, {1'b1, 5'h07, 8'ha5});
        chk(14'(lat), 14'h0000);
        run(move_swap_pkg::IDLE_WORD);
        chk({working_r, 5'h00, fw.en}, {8'ha5, 6'h00});
        run(12'h800);
        chk({working_r, 5'h00, fw.en}, {8'ha5, 6'h00});
    endtask
    // move to working and back to file, zero flag both ways
    task automatic sc_move();
        poke(5'h03, 8'h00);
        poke(5'h04, 8'h3c);
        run({move_swap_pkg::MOVE_FILE_TOP, 1'b0, 5'h04});
        chk({working_r, 5'h00, zero_flag_r}, {8'h3c, 6'h00});
        chk(14'(lat), 14'h0001);
        run({move_swap_pkg::MOVE_FILE_TOP, 1'b1, 5'h03});
        chk(fw, {1'b1, 5'h03, 8'h00});
        chk({working_r, 5'h00, zero_flag_r}, {8'h3c, 6'h01});
    endtask
    // nibble exchange to working then to file, flag left alone
    task automatic sc_swap();
        poke(5'h09, 8'ha5);
        run({move_swap_pkg::SWAP_TOP, 1'b0, 5'h09});
        chk({working_r, 5'h00, zero_flag_r}, {8'h5a, 6'h01});
        run({move_swap_pkg::SWAP_TOP, 1'b1, 5'h09});
        chk(fw, {1'b1, 5'h09, 8'h5a});
        run(12'hc81);
        chk({working_r, 5'h00, zero_flag_r}, {8'h81, 6'h01});
    endtask
    // store then move on one address back to back, then a word offered while busy
    task automatic sc_pipe();
        run(12'hc3f);
        chk(14'(lat), 14'h0000);
        @(posedge clk);
        insn_in <= {1'b1, move_swap_pkg::STORE_TOP, 5'h0a};
        @(posedge clk);
        insn_in <= {1'b1, move_swap_pkg::MOVE_FILE_TOP, 1'b0, 5'h0a};
        @(posedge clk);
        insn_in <= {1'b1, 12'hc00};
        #1;
        chk({busy, 12'h000, done_r}, 14'h2000);
        @(posedge clk);
        insn_in <= '0;
        #1;
        chk({working_r, 4'h0, done_r, zero_flag_r}, {8'h3f, 6'h02});
        @(posedge clk);
        #1;
        chk({working_r, 4'h0, done_r, zero_flag_r}, {8'h3f, 6'h00});
    endtask
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // reset, then the scenarios
    initial begin
        reset_n = 1'b0;
        insn_in = '0;
        ext_wr_en = 1'b0;
        ext_wr_addr = 5'h00;
        ext_wr_data = 8'h00;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        sc_flat();
        sc_move();
        sc_swap();
        sc_pipe();
        report_and_stop();
    end
endmodule
